// File: verilog/serial_port_params.svh
// Constants for the serial port: register indexes, field positions, reset values, timing.
// Assumes it is included by its bare name from the design files that need it.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indexes; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------------
`define IDX_CONTROL_HIGH   8'h04
`define IDX_CONTROL_LOW    8'h05
`define IDX_DATA_BUFFER    8'h06
`define IDX_BAUD_DIVISOR   8'hf5

// ----------------------------------------------------------------------------
// Field positions of control_high and control_low.
// ----------------------------------------------------------------------------
`define CH_MODE_HI         7
`define CH_MODE_LO         6
`define CH_RE              4
`define CH_TB8             3
`define CH_RB8             2
`define CH_RIE             1
`define CH_RIP             0
`define CL_PAR_EN          7
`define CL_CSEL_HI         3
`define CL_CSEL_LO         2
`define CL_TIE             1
`define CL_TIP             0

// ----------------------------------------------------------------------------
// Reset values and timing counts.
// ----------------------------------------------------------------------------
`define CTRL_RESET         8'h00
`define BAUD_RESET         8'h00
`define PH_MID             4'h7
`define PH_LAST            4'hf
`define BIT_LAST8          4'h7
`define BIT_LAST9          4'h8

`endif

// File: verilog/serial_port_pkg.sv
// Types shared by the serial port design: modes, sequencer states and state records.
// Assumes the constants header is available to the modules that use these types.
package serial_port_pkg;

   typedef enum logic [1:0] {
      MODE_SHIFT  = 2'b00,
      MODE_ASYNC8 = 2'b01,
      MODE_FIXED9 = 2'b10,
      MODE_VAR9   = 2'b11
   } mode_t;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_START = 2'b01,
      TX_DATA  = 2'b11,
      TX_STOP  = 2'b10
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } rx_state_t;

   typedef struct packed {
      logic [2:0] pre;
      logic [7:0] div;
      logic       tick;
   } baud_state_t;

   typedef struct packed {
      logic [7:0] ctl_h;
      logic [7:0] ctl_l;
      logic [7:0] baud;
      logic [7:0] rx_hold;
      logic [7:0] rdata;
      logic       ack;
      logic       s1;
      logic       s2;
      logic       s3;
      logic       rx_f;
      tx_state_t  tx_st;
      logic [3:0] tx_ph;
      logic [3:0] tx_cnt;
      logic [8:0] tx_shift;
      logic       sync_op;
      logic       m0_rx;
      logic       txd;
      logic       dat_out;
      logic       dat_oe_n;
      rx_state_t  rx_st;
      logic [3:0] rx_ph;
      logic [3:0] rx_cnt;
      logic [8:0] rx_shift;
   } core_state_t;

endpackage : serial_port_pkg

// File: verilog/baud_tick_gen.sv
// Baud generator: selects the port clock and divides it to the sixteen-times bit tick.
// Assumes one system clock; the selected port clock is an enable, not a clock.
`timescale 1ns/1ns
`include "serial_port_params.svh"

module baud_tick_gen
   import serial_port_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic       reset_n_in,
   input  wire logic [1:0] clock_select_in,
   input  wire logic [7:0] divisor_in,
   input  wire logic       fixed_rate_in,
   output logic            os_tick_out
);

   baud_state_t q;
   baud_state_t d;
   logic        fu_tick;

   // Port clock is the system clock divided by 1, 2, 4 or 8.
   always_comb begin
      d = q;
      d.pre = q.pre + 3'h1;
      case (clock_select_in)
         2'b00:   fu_tick = 1'b1;
         2'b01:   fu_tick = q.pre[0];
         2'b10:   fu_tick = &q.pre[1:0];
         default: fu_tick = &q.pre;
      endcase
      d.tick = 1'b0;
      if (fu_tick) begin
         // Greater-or-equal, so a divisor lowered mid-count never waits out a full wrap.
         if (fixed_rate_in || q.div >= divisor_in) begin
            d.div  = 8'h00;
            d.tick = 1'b1;
         end else begin
            d.div = q.div + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign os_tick_out = q.tick;

endmodule : baud_tick_gen

// File: verilog/serial_port_baud_mode0_mode1.sv
// Serial port with baud generator, synchronous shift mode and asynchronous framing.
// Assumes an Avalon-MM master on the system clock and a remote device on the two pins.
//
// Functional notes
// - Shift mode bit rate is port clock over 16 times divisor plus one.
// - Mode 2 uses port clock over 16 and ignores the divisor.
// - Modes 1 and 3 use port clock over 16 times divisor plus one.
// - Shift mode moves data on the data pin, clock on the output pin.
// - Shift mode moves exactly eight bits, least significant first.
// - Mode field 00 in control high bits 7:6 selects shift mode.
// - Mode field 01 selects the 8-bit asynchronous port.
// - Writing the data buffer loads the shifter and starts sending.
// - Shift mode reception starts only while the receive flag is zero.
// - Reception also needs the receive enable bit 4 set.
// - Shift reception gives eight clock pulses, one data sample each.
// - Receive interrupt request only while its enable bit 1 is set.
// - Mode 1 frame is start low, eight bits LSB first, stop high.
// - Mode 1 transmit adds start and stop bits in hardware.
// - Mode 1 reception starts on a low level with receive enabled.
// - Control low bits 3:2 select the port clock source.
// - Control low bit 7 enables transmit parity generation.
// - Receive flag sets after bit eight or at stop bit middle.
// - Transmit flag sets after bit eight or at stop bit start.
// - Data buffer reads return a holding register apart from transmit.
// - Both control registers reset to zero.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`include "serial_port_params.svh"

module serial_port_baud_mode0_mode1
   import serial_port_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        reset_n_in,
   input  wire logic [9:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        serial_data_pin_in,
   output logic             serial_data_pin_out,
   output logic             serial_data_pin_oe_n_out,
   output logic             serial_output_pin_out,
   output logic             rx_irq_out,
   output logic             tx_irq_out
);

   // -------------------------------------------------------------------------
   // State and helper signals
   // -------------------------------------------------------------------------
   core_state_t q;
   core_state_t d;
   mode_t       mode;
   logic        req;
   logic        wr_en;
   logic        wr_data;
   logic        os_tick;
   logic        ninth;
   logic        rip_set;
   logic        tip_set;
   logic [3:0]  last_bit;
   logic [7:0]  idx;
   logic [7:0]  wdata;
   logic [7:0]  rd_mux;

   assign mode    = mode_t'(q.ctl_h[`CH_MODE_HI:`CH_MODE_LO]);
   assign req     = avs_read_in | avs_write_in;
   assign idx     = avs_address_in[9:2];
   assign wdata   = avs_writedata_in[7:0];
   assign wr_en   = avs_write_in & q.ack & avs_byteenable_in[0];
   assign wr_data = wr_en && idx == `IDX_DATA_BUFFER;

   // Parity only has a frame slot in the nine-bit modes.
   assign ninth   = q.ctl_l[`CL_PAR_EN] ? ^wdata : q.ctl_h[`CH_TB8];

   // Shift mode and mode 1 carry eight bits; modes 2 and 3 carry nine.
   assign last_bit = (mode == MODE_SHIFT || mode == MODE_ASYNC8) ?
                     `BIT_LAST8 : `BIT_LAST9;

   // -------------------------------------------------------------------------
   // Bit clock
   // -------------------------------------------------------------------------
   baud_tick_gen u_baud (
      .clk_sys_in      (clk_sys_in),
      .reset_n_in      (reset_n_in),
      .clock_select_in (q.ctl_l[`CL_CSEL_HI:`CL_CSEL_LO]),
      .divisor_in      (q.baud),
      .fixed_rate_in   (mode == MODE_FIXED9),
      .os_tick_out     (os_tick)
   );

   // -------------------------------------------------------------------------
   // Register read selection
   // -------------------------------------------------------------------------
   always_comb begin
      case (idx)
         `IDX_CONTROL_HIGH: rd_mux = q.ctl_h;
         `IDX_CONTROL_LOW:  rd_mux = q.ctl_l;
         `IDX_DATA_BUFFER:  rd_mux = q.rx_hold;
         `IDX_BAUD_DIVISOR: rd_mux = q.baud;
         default:           rd_mux = 8'h00;
      endcase
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      d       = q;
      rip_set = 1'b0;
      tip_set = 1'b0;

      // Pin input passes three flops; a level counts once the last two agree.
      d.s1 = serial_data_pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.rx_f = q.s3;
      end

      // Every access waits exactly one cycle; read data is caught in that cycle.
      d.ack = req & ~q.ack;
      if (req && !q.ack) begin
         d.rdata = rd_mux;
      end

      if (wr_en) begin
         case (idx)
            `IDX_CONTROL_HIGH: d.ctl_h = wdata;
            `IDX_CONTROL_LOW:  d.ctl_l = wdata;
            `IDX_BAUD_DIVISOR: d.baud  = wdata;
            default:           d.baud  = q.baud;
         endcase
      end

      // Transmit and shift sequencer. A data write restarts it at once.
      if (wr_data) begin
         d.tx_shift = {ninth, wdata};
         d.tx_ph    = 4'h0;
         d.tx_cnt   = 4'h0;
         d.m0_rx    = 1'b0;
         if (mode == MODE_SHIFT) begin
            d.sync_op = 1'b1;
            d.tx_st   = TX_DATA;
         end else begin
            d.sync_op = 1'b0;
            d.tx_st   = TX_START;
         end
      end else if (q.tx_st == TX_IDLE) begin
         if (mode == MODE_SHIFT && q.ctl_h[`CH_RE] && !q.ctl_h[`CH_RIP]) begin
            d.sync_op = 1'b1;
            d.m0_rx   = 1'b1;
            d.tx_ph   = 4'h0;
            d.tx_cnt  = 4'h0;
            d.tx_st   = TX_DATA;
         end
      end else if (os_tick) begin
         d.tx_ph = q.tx_ph + 4'h1;
         case (q.tx_st)
            TX_START: begin
               if (q.tx_ph == `PH_LAST) begin
                  d.tx_st = TX_DATA;
               end
            end
            TX_DATA: begin
               // The shift clock rises after the middle tick; sample there.
               if (q.sync_op && q.m0_rx && q.tx_ph == `PH_MID) begin
                  d.rx_shift = {q.rx_f, q.rx_shift[8:1]};
               end
               if (q.tx_ph == `PH_LAST) begin
                  d.tx_shift = {1'b0, q.tx_shift[8:1]};
                  d.tx_cnt   = q.tx_cnt + 4'h1;
                  if (q.tx_cnt == last_bit) begin
                     if (q.sync_op) begin
                        d.tx_st = TX_IDLE;
                        if (q.m0_rx) begin
                           d.rx_hold = q.rx_shift[8:1];
                           rip_set   = 1'b1;
                        end else begin
                           tip_set = 1'b1;
                        end
                     end else begin
                        d.tx_st = TX_STOP;
                        tip_set = 1'b1;
                     end
                  end
               end
            end
            TX_STOP: begin
               if (q.tx_ph == `PH_LAST) begin
                  d.tx_st = TX_IDLE;
               end
            end
            default: d.tx_st = TX_IDLE;
         endcase
      end

      // Asynchronous receiver, idle in shift mode.
      if (q.rx_st == RX_IDLE) begin
         if (mode != MODE_SHIFT && q.ctl_h[`CH_RE] && !q.rx_f) begin
            d.rx_st  = RX_START;
            d.rx_ph  = 4'h0;
            d.rx_cnt = 4'h0;
         end
      end else if (os_tick) begin
         d.rx_ph = q.rx_ph + 4'h1;
         if (q.rx_ph == `PH_MID) begin
            case (q.rx_st)
               RX_START: begin
                  // A start bit gone high by mid-bit was noise.
                  d.rx_st = q.rx_f ? RX_IDLE : RX_DATA;
               end
               RX_DATA: begin
                  d.rx_shift = {q.rx_f, q.rx_shift[8:1]};
                  d.rx_cnt   = q.rx_cnt + 4'h1;
                  if (q.rx_cnt == last_bit) begin
                     d.rx_st = RX_STOP;
                  end
               end
               RX_STOP: begin
                  d.rx_st = RX_IDLE;
                  rip_set = 1'b1;
                  if (last_bit == `BIT_LAST8) begin
                     d.rx_hold = q.rx_shift[8:1];
                  end else begin
                     d.rx_hold             = q.rx_shift[7:0];
                     d.ctl_h[`CH_RB8]      = q.rx_shift[8];
                  end
               end
               default: d.rx_st = RX_IDLE;
            endcase
         end
      end

      // Hardware sets come after the bus write, so a set beats a clear.
      if (rip_set) begin
         d.ctl_h[`CH_RIP] = 1'b1;
      end
      if (tip_set) begin
         d.ctl_l[`CL_TIP] = 1'b1;
      end

      // Pin drive, all from flops.
      case (d.tx_st)
         TX_START: d.txd = 1'b0;
         TX_DATA:  d.txd = d.sync_op ? d.tx_ph[3] : d.tx_shift[0];
         default:  d.txd = 1'b1;
      endcase
      d.dat_out  = d.tx_shift[0];
      d.dat_oe_n = ~(d.tx_st == TX_DATA && d.sync_op && !d.m0_rx);
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q          <= '0;
         q.ctl_h    <= `CTRL_RESET;
         q.ctl_l    <= `CTRL_RESET;
         q.baud     <= `BAUD_RESET;
         q.s1       <= 1'b1;
         q.s2       <= 1'b1;
         q.s3       <= 1'b1;
         q.rx_f     <= 1'b1;
         q.txd      <= 1'b1;
         q.dat_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign avs_readdata_out         = {24'h000000, q.rdata};
   assign avs_waitrequest_out      = req & ~q.ack;
   assign serial_data_pin_out      = q.dat_out;
   assign serial_data_pin_oe_n_out = q.dat_oe_n;
   assign serial_output_pin_out    = q.txd;
   assign rx_irq_out               = q.ctl_h[`CH_RIP] & q.ctl_h[`CH_RIE];
   assign tx_irq_out               = q.ctl_l[`CL_TIP] & q.ctl_l[`CL_TIE];

endmodule : serial_port_baud_mode0_mode1

// File: test/serial_port_sva.sv
// Checker for the serial port, seeing only the top ports.
// Assumes control fields can be mirrored from completed bus writes.
`timescale 1ns/1ns
`include "serial_port_params.svh"
module serial_port_sva
   import serial_port_pkg::*;
(
   input wire logic        clk_sys_in,
   input wire logic        reset_n_in,
   input wire logic [9:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        serial_data_pin_in,
   input wire logic        serial_data_pin_out,
   input wire logic        serial_data_pin_oe_n_out,
   input wire logic        serial_output_pin_out,
   input wire logic        rx_irq_out,
   input wire logic        tx_irq_out
);
   // ---------------------------------------------------------------
   // Mirror of control_high and a count of shift clock rises.
   // ---------------------------------------------------------------
   logic [7:0] ch_q;
   logic [3:0] rise_q;
   logic       wr_ok;
   logic       wr_h;
   logic       wr_d;
   assign wr_ok = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
   assign wr_h  = wr_ok & (avs_address_in[9:2] == `IDX_CONTROL_HIGH);
   assign wr_d  = wr_ok & (avs_address_in[9:2] == `IDX_DATA_BUFFER);
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ch_q   <= `CTRL_RESET;
         rise_q <= 4'h0;
      end else begin
         if (wr_h)
            ch_q <= avs_writedata_in[7:0];
         if (serial_data_pin_oe_n_out)
            rise_q <= 4'h0;
         else if ($rose(serial_output_pin_out))
            rise_q <= rise_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);
   property p_shift_start;
      wr_d && ch_q[7:6] == MODE_SHIFT |-> ##[1:3] !serial_data_pin_oe_n_out;
   endproperty
   a_shift_start: assert property (p_shift_start) else $error("no shift start");
   property p_async_start;
      wr_d && ch_q[7:6] == MODE_ASYNC8 |-> ##[1:3] !serial_output_pin_out;
   endproperty
   a_async_start: assert property (p_async_start) else $error("no start bit");
   property p_eight;
      $rose(serial_data_pin_oe_n_out) |-> rise_q == 4'h8;
   endproperty
   a_eight: assert property (p_eight) else $error("shift count wrong");
   property p_stop;
      $rose(tx_irq_out) && ch_q[7:6] == MODE_ASYNC8 |-> serial_output_pin_out [*8];
   endproperty
   a_stop: assert property (p_stop) else $error("flag not at stop bit");
   property p_rx_irq;
      rx_irq_out |-> ch_q[`CH_RIE];
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("irq while masked");
   property p_rx_hold;
      $fell(rx_irq_out) |-> $past(wr_h);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("flag dropped by itself");
   property p_reset;
      $rose(reset_n_in) |-> serial_data_pin_oe_n_out && !rx_irq_out && !tx_irq_out;
   endproperty
   a_reset: assert property (p_reset) else $error("bad state after reset");
   property p_rx_gate;
      $fell(serial_output_pin_out) && serial_data_pin_oe_n_out && ch_q[7:6] == MODE_SHIFT
         |-> ch_q[`CH_RE];
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("receive while disabled");
endmodule : serial_port_sva
bind serial_port_baud_mode0_mode1 serial_port_sva i_serial_port_sva (
   .clk_sys_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
   .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
   .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe_n_out,
   .serial_output_pin_out, .rx_irq_out, .tx_irq_out);

// File: test/remote_serial_model.sv
// Remote serial partner: feeds and captures shift bytes and asynchronous frames.
// Assumes the bench sets the framing kind and the bit length in system clocks.
`timescale 1ns/1ns
module remote_serial_model (
   input  wire logic        clk_sys_in,
   input  wire logic        async_in,
   input  wire logic [11:0] bit_cycles_in,
   input  wire logic        data_in,
   input  wire logic        data_oe_n_in,
   input  wire logic        tx_pin_in,
   output logic             line_out,
   output logic [7:0]       got_out,
   output logic             stop_out
);
   // ---------------------------------------------------------------
   // Line drive and capture.
   // ---------------------------------------------------------------
   logic [7:0] sh_q = 8'hff;
   logic       adrv = 1'b1;
   initial got_out = 8'h00;
   initial stop_out = 1'b0;
   // The idle line is pulled up; a spent shift bit is followed by its inverse.
   assign line_out = !data_oe_n_in ? data_in : (async_in ? adrv : sh_q[0]);
   always @(posedge tx_pin_in) begin
      if (!async_in && !data_oe_n_in)
         got_out <= {data_in, got_out[7:1]};
      if (!async_in && data_oe_n_in)
         sh_q <= {~sh_q[0], sh_q[7:1]};
   end
   initial forever begin
      @(negedge tx_pin_in);
      if (async_in) begin
         repeat (bit_cycles_in / 2) @(posedge clk_sys_in);
         for (int k = 0; k < 8; k++) begin
            repeat (bit_cycles_in) @(posedge clk_sys_in);
            got_out <= {tx_pin_in, got_out[7:1]};
         end
         repeat (bit_cycles_in) @(posedge clk_sys_in);
         stop_out <= tx_pin_in;
      end
   end
   task automatic load(input logic [7:0] b);
      sh_q = b;
   endtask : load
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         adrv <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
         repeat (bit_cycles_in) @(posedge clk_sys_in);
      end
   endtask : send
   task automatic glitch;
      adrv <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      adrv <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
   endtask : glitch
endmodule : remote_serial_model

// File: test/testbench.sv
// Testbench for the serial port: bus tasks, one task a scenario, one verdict.
// Assumes the remote model on the pins and the checker bound to the top.
`timescale 1ns/1ns
`include "serial_port_params.svh"
module testbench
   import serial_port_pkg::*;
();
   logic        clk_sys_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic [9:0]  avs_address_in = 10'h000;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h00000000;
   logic [3:0]  avs_byteenable_in = 4'h0;
   logic [31:0] avs_readdata_out;
   logic        avs_waitrequest_out, serial_data_pin_in, serial_data_pin_out;
   logic        serial_data_pin_oe_n_out, serial_output_pin_out, rx_irq_out, tx_irq_out;
   logic        async_mode = 1'b0;
   logic        stop_bit;
   logic [11:0] bit_cycles = 12'h010;
   logic [7:0]  got, rd;
   int          fail_count = 0, check_count = 0, n;
   serial_port_baud_mode0_mode1 i_serial_port_baud_mode0_mode1 (.clk_sys_in, .reset_n_in,
      .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
      .avs_readdata_out, .avs_waitrequest_out, .serial_data_pin_in, .serial_data_pin_out,
      .serial_data_pin_oe_n_out, .serial_output_pin_out, .rx_irq_out, .tx_irq_out);
   remote_serial_model i_remote_serial_model (.clk_sys_in, .async_in(async_mode),
      .bit_cycles_in(bit_cycles), .data_in(serial_data_pin_out),
      .data_oe_n_in(serial_data_pin_oe_n_out), .tx_pin_in(serial_output_pin_out),
      .line_out(serial_data_pin_in), .got_out(got), .stop_out(stop_bit));
   always #20 clk_sys_in = ~clk_sys_in;
   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task automatic bad(input string m);
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
   endtask : bad
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      check_count++;
      if (g !== e)
         bad(m);
   endtask : chk8
   // Counts allow four cycles for synchroniser and tick phase.
   task automatic chk_n(input int g, input int e, input string m);
      check_count++;
      if (g < e - 4 || g > e + 4)
         bad(m);
   endtask : chk_n
   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                      input logic [3:0] be);
      int k;
      avs_address_in    <= {i, 2'b00};
      avs_writedata_in  <= {24'h000000, d};
      avs_byteenable_in <= be;
      avs_write_in      <= w;
      avs_read_in       <= ~w;
      k = 0;
      do begin
         @(posedge clk_sys_in);
         k++;
      end while (avs_waitrequest_out !== 1'b0 && k < 20);
      rd = avs_readdata_out[7:0];
      avs_write_in <= 1'b0;
      avs_read_in  <= 1'b0;
      @(posedge clk_sys_in);
      if (k >= 20) begin
         bad("bus hang");
         end_of_test();
      end
   endtask : bus
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      bus(1'b1, i, d, 4'h1);
   endtask : wr
   task automatic expect_reg(input logic [7:0] i, input logic [7:0] e, input string m);
      bus(1'b0, i, 8'h00, 4'h1);
      chk8(rd, e, m);
   endtask : expect_reg
   task automatic wait_irq(input logic rx, input int lim);
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while ((rx ? rx_irq_out : tx_irq_out) !== 1'b1 && n < lim);
      if (n >= lim) begin
         bad("irq timeout");
         end_of_test();
      end
   endtask : wait_irq
   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic test_regs;
      expect_reg(`IDX_CONTROL_HIGH, `CTRL_RESET, "control high reset");
      expect_reg(`IDX_CONTROL_LOW, `CTRL_RESET, "control low reset");
      wr(`IDX_BAUD_DIVISOR, 8'ha5);
      bus(1'b1, `IDX_BAUD_DIVISOR, 8'h3c, 4'h0);
      expect_reg(`IDX_BAUD_DIVISOR, 8'ha5, "divisor");
      expect_reg(8'h3f, 8'h00, "unmapped");
      $display("test_regs done");
   endtask : test_regs
   task automatic test_shift;
      wr(`IDX_BAUD_DIVISOR, 8'h01);
      wr(`IDX_CONTROL_LOW, 8'h02);
      wr(`IDX_DATA_BUFFER, 8'h96);
      wait_irq(1'b0, 600);
      chk_n(n, 257, "shift rate");
      chk8(got, 8'h96, "shift byte sent");
      repeat (40) @(posedge clk_sys_in);
      chk8({7'h00, tx_irq_out}, 8'h01, "flag held");
      wr(`IDX_CONTROL_LOW, 8'h02);
      i_remote_serial_model.load(8'h3c);
      wr(`IDX_CONTROL_HIGH, 8'h12);
      wait_irq(1'b1, 600);
      expect_reg(`IDX_DATA_BUFFER, 8'h3c, "shift byte received");
      n = 0;
      repeat (300) begin
         @(posedge clk_sys_in);
         n += int'(serial_output_pin_out !== 1'b1);
      end
      chk_n(n, 0, "clock while flag set");
      wr(`IDX_CONTROL_HIGH, 8'h00);
      $display("test_shift done");
   endtask : test_shift
   task automatic test_async_tx;
      logic [1:0] md [5] = '{2'b01, 2'b01, 2'b10, 2'b11, 2'b01};
      logic [7:0] dv [5] = '{8'h00, 8'h01, 8'h05, 8'h01, 8'h00};
      logic [1:0] sl [5] = '{2'b00, 2'b00, 2'b10, 2'b00, 2'b01};
      int         bc;
      async_mode <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         bc = (16 * ((md[i] == 2'b10) ? 1 : dv[i] + 1)) << sl[i];
         bit_cycles <= bc[11:0];
         wr(`IDX_BAUD_DIVISOR, dv[i]);
         wr(`IDX_CONTROL_LOW, {(md[i] == 2'b11), 3'h0, sl[i], 2'b10});
         wr(`IDX_CONTROL_HIGH, {md[i], 6'h00});
         wr(`IDX_DATA_BUFFER, 8'ha7);
         wait_irq(1'b0, 3000);
         chk_n(n, bc * ((md[i] == 2'b01) ? 9 : 10) + 1, "frame time");
         repeat (2 * bc) @(posedge clk_sys_in);
         if (md[i] == 2'b01) begin
            chk8(got, 8'ha7, "async byte");
            chk8({7'h00, stop_bit}, 8'h01, "stop bit");
         end else if (md[i] == 2'b11) begin
            chk8({7'h00, stop_bit}, 8'h01, "parity bit");
         end
         wr(`IDX_CONTROL_LOW, 8'h00);
      end
      $display("test_async_tx done");
   endtask : test_async_tx
   task automatic test_async_rx;
      bit_cycles <= 12'h010;
      wr(`IDX_BAUD_DIVISOR, 8'h00);
      wr(`IDX_CONTROL_HIGH, 8'h50);
      i_remote_serial_model.send(8'h5b);
      repeat (20) @(posedge clk_sys_in);
      chk8({7'h00, rx_irq_out}, 8'h00, "irq masked");
      bus(1'b0, `IDX_CONTROL_HIGH, 8'h00, 4'h1);
      chk8(rd & 8'hfb, 8'h51, "receive flag");
      expect_reg(`IDX_DATA_BUFFER, 8'h5b, "async byte received");
      wr(`IDX_CONTROL_HIGH, 8'h52);
      i_remote_serial_model.glitch();
      repeat (300) @(posedge clk_sys_in);
      chk8({7'h00, rx_irq_out}, 8'h00, "false start");
      i_remote_serial_model.send(8'hc4);
      wait_irq(1'b1, 50);
      expect_reg(`IDX_DATA_BUFFER, 8'hc4, "byte after false start");
      $display("test_async_rx done");
   endtask : test_async_rx
   initial begin
      repeat (2) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      @(posedge clk_sys_in);
      test_regs();
      test_shift();
      test_async_tx();
      test_async_rx();
      end_of_test();
   end
endmodule : testbench
